// [logic/serial_port_zero_defs.svh]
`ifndef SERIAL_PORT_ZERO_DEFS_SVH
`define SERIAL_PORT_ZERO_DEFS_SVH

// Register offsets on the 8-bit register port.
`define OFS_POWER_CONTROL 8'h87
`define OFS_SERIAL_CONTROL 8'h98
`define OFS_SERIAL_DATA_BUFFER 8'h99
`define OFS_INT_ENABLE 8'hA8
`define OFS_SERIAL_SLAVE_ADDRESS 8'hA9
`define OFS_SLAVE_ADDRESS_MASK 8'hB9

// Field positions in serial_control.
`define SC_MODE_HIGH 7
`define SC_MODE_LOW 6
`define SC_MULTIPROC 5
`define SC_RX_ENABLE 4
`define SC_TX_NINTH 3
`define SC_RX_NINTH 2
`define SC_TX_FLAG 1
`define SC_RX_FLAG 0

// Field positions in power_control and in the interrupt enable register.
`define PC_BAUD_DOUBLER 7
`define PC_FRAMING_DETECT 6
`define IE_GLOBAL 7
`define IE_SERIAL_ZERO 4

// Reset values.
`define RST_BYTE 8'h00

// Timing counts: dividers in 10 MHz oscillator clocks or timer ticks, positions in sixteenth-bit ticks or data bits.
`define M0_DIV_SLOW 4'hC
`define M0_DIV_FAST 4'h4
`define M2_OS_DIV_NORMAL 3'h4
`define M2_OS_DIV_DOUBLE 3'h2
`define TMR_OS_DIV_NORMAL 3'h2
`define TMR_OS_DIV_DOUBLE 3'h1
`define OS_PER_BIT_LAST 4'hF
`define OS_MID_BIT 4'h7
`define DATA_BITS_LAST 3'h7

`endif

// [logic/serial_port_zero_pkg.sv]
`default_nettype none
package serial_port_zero_pkg;

   typedef enum logic [1:0]
   {
      MODE_SYNC = 2'h0,
      MODE_ASYNC_TEN = 2'h1,
      MODE_ASYNC_FIXED = 2'h2,
      MODE_ASYNC_VAR = 2'h3
   } serial_mode_e;

   typedef enum logic [2:0]
   {
      FR_IDLE = 3'h0,
      FR_START = 3'h1,
      FR_DATA = 3'h3,
      FR_NINTH = 3'h2,
      FR_STOP = 3'h6
   } frame_state_e;

endpackage
`default_nettype wire

// [logic/serial_rate_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface serial_rate_if
   import serial_port_zero_pkg::*;
   ();
   logic clock_en;
   serial_mode_e mode;
   logic doubler;
   logic mp_bit;
   logic timer_tick;
   logic os_tick;
   logic shift_tick;
   logic shift_low;

   modport gen (input clock_en, input mode, input doubler, input mp_bit, input timer_tick,
      output os_tick, output shift_tick, output shift_low);
   modport user (output clock_en, output mode, output doubler, output mp_bit, output timer_tick,
      input os_tick, input shift_tick, input shift_low);
endinterface
`default_nettype wire

// [logic/serial_rate_gen.sv]
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_zero_defs.svh"
module serial_rate_gen
   import serial_port_zero_pkg::*;
   (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   serial_rate_if.gen rate
   );

   logic [3:0] phase;
   logic [3:0] shift_div;
   logic [2:0] os_cnt;
   logic [2:0] os_div;
   logic os_source;

   always_comb
   begin
      shift_div = rate.mp_bit ? `M0_DIV_FAST : `M0_DIV_SLOW; // R2
      if (rate.mode == MODE_ASYNC_FIXED)
      begin
         os_source = 1'b1;
         os_div = rate.doubler ? `M2_OS_DIV_DOUBLE : `M2_OS_DIV_NORMAL; // R15
      end
      else
      begin
         os_source = rate.timer_tick; // R18
         os_div = rate.doubler ? `TMR_OS_DIV_DOUBLE : `TMR_OS_DIV_NORMAL; // R15
      end
   end

   assign rate.shift_tick = rate.clock_en && (phase == shift_div - 4'h1);
   assign rate.shift_low = (phase < {1'b0, shift_div[3:1]});
   assign rate.os_tick = rate.clock_en && os_source && (os_cnt == os_div - 3'h1);

   // Mode 0 shift clock phase.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
         phase <= 4'h0;
      else if (rate.clock_en)
         phase <= (phase >= shift_div - 4'h1) ? 4'h0 : phase + 4'h1;
   end

   // Sixteenth-of-a-bit tick for the asynchronous modes.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
         os_cnt <= 3'h0;
      else if (rate.clock_en && os_source)
         os_cnt <= (os_cnt >= os_div - 3'h1) ? 3'h0 : os_cnt + 3'h1;
   end
endmodule
`default_nettype wire

// [logic/serial_port_zero_uart.sv]
// Overview of operation
// (R1) Mode bits pick sync, 10-bit or 11-bit frames.
// (R2) Mode 0 clock is osc/12 or osc/4.
// (R3) Bit 7 is mode-high or framing error flag.
// (R4) Bad stop bit sets framing flag; software clears.
// (R5) Modes 2/3 multiprocessor: ninth bit 0 blocks receive.
// (R6) Mode 1 multiprocessor: bad stop blocks receive.
// (R7) Reception only while receive enable is set.
// (R8) Modes 2/3 send transmit ninth bit.
// (R9) Receive ninth bit captures ninth or stop bit.
// (R10) Transmit flag at bit eight or stop start.
// (R11) Receive flag at bit eight or mid stop.
// (R12) Data address: read receive, write transmit buffer.
// (R13) Software loads slave address for address recognition.
// (R14) Interrupt needs serial and global enables set.
// (R15) Baud doubler doubles rate in modes 1-3.
// (R16) Mask bit zero makes address bit don't-care.
// (R17) Framing detect enable turns bit 7 into flag.
// (R18) Timer overflow ticks time variable-rate modes.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_zero_defs.svh"
module serial_port_zero_uart
   import serial_port_zero_pkg::*;
   (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_clock_en,
   input wire logic [7:0] i_address,
   input wire logic [7:0] i_write_data,
   input wire logic i_write,
   input wire logic i_read,
   output logic [7:0] o_read_data,
   input wire logic i_timer_tick,
   input wire logic i_rxd,
   output logic o_rxd,
   output logic o_rxd_oe,
   output logic o_txd,
   output logic o_serial_irq
   );

   serial_rate_if rate ();

   logic mode_select_high;
   logic mode_select_low;
   logic multiprocessor_bit;
   logic receive_enable;
   logic transmit_ninth_bit;
   logic receive_ninth_bit;
   logic transmit_flag;
   logic receive_flag;
   logic framing_error_flag;
   logic baud_doubler;
   logic framing_detect_enable;
   logic global_int_enable;
   logic serial_zero_int_enable;
   logic [7:0] serial_slave_address;
   logic [7:0] slave_address_mask;
   logic [7:0] rx_buffer;
   serial_mode_e mode;
   logic write_control;
   logic write_data;

   frame_state_e tx_state;
   logic [3:0] tx_os;
   logic [2:0] tx_bit;
   logic [8:0] tx_shift;
   logic tx_set_flag;

   frame_state_e rx_state;
   logic [3:0] rx_os;
   logic [2:0] rx_bit;
   logic [7:0] rx_shift;
   logic rx_ninth;
   logic rx_done;
   logic rx_accept;
   logic next_rx_ninth_bit;
   logic rx_stop_bad;

   logic rx_sync1;
   logic rx_sync2;
   logic rx_sync3;
   logic rx_level;
   logic rx_level_prev;

   assign mode = serial_mode_e'({mode_select_high, mode_select_low}); // R1
   assign write_control = i_write && (i_address == `OFS_SERIAL_CONTROL);
   assign write_data = i_write && (i_address == `OFS_SERIAL_DATA_BUFFER);

   assign rate.clock_en = i_clock_en;
   assign rate.mode = mode;
   assign rate.doubler = baud_doubler;
   assign rate.mp_bit = multiprocessor_bit;
   assign rate.timer_tick = i_timer_tick;

   serial_rate_gen u_rate
   (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .rate(rate)
   );

   // Software-owned control bits. Bit 7 lands on the framing flag instead while detection is on.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         mode_select_high <= 1'b0;
         mode_select_low <= 1'b0;
         multiprocessor_bit <= 1'b0;
         receive_enable <= 1'b0;
         transmit_ninth_bit <= 1'b0;
      end
      else if (i_clock_en && write_control)
      begin
         if (!framing_detect_enable)
            mode_select_high <= i_write_data[`SC_MODE_HIGH]; // R3 R17
         mode_select_low <= i_write_data[`SC_MODE_LOW];
         multiprocessor_bit <= i_write_data[`SC_MULTIPROC];
         receive_enable <= i_write_data[`SC_RX_ENABLE];
         transmit_ninth_bit <= i_write_data[`SC_TX_NINTH];
      end
   end

   // Other registers on the port.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         baud_doubler <= 1'b0;
         framing_detect_enable <= 1'b0;
         global_int_enable <= 1'b0;
         serial_zero_int_enable <= 1'b0;
         serial_slave_address <= `RST_BYTE;
         slave_address_mask <= `RST_BYTE;
      end
      else if (i_clock_en && i_write)
      begin
         case (i_address)
            `OFS_POWER_CONTROL:
            begin
               baud_doubler <= i_write_data[`PC_BAUD_DOUBLER];
               framing_detect_enable <= i_write_data[`PC_FRAMING_DETECT];
            end
            `OFS_INT_ENABLE:
            begin
               global_int_enable <= i_write_data[`IE_GLOBAL];
               serial_zero_int_enable <= i_write_data[`IE_SERIAL_ZERO];
            end
            `OFS_SERIAL_SLAVE_ADDRESS: serial_slave_address <= i_write_data; // R13
            `OFS_SLAVE_ADDRESS_MASK: slave_address_mask <= i_write_data;
            default: ;
         endcase
      end
   end

   // Hardware-set flags: a set in the same cycle as a software write wins.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         transmit_flag <= 1'b0;
         receive_flag <= 1'b0;
         receive_ninth_bit <= 1'b0;
         framing_error_flag <= 1'b0;
      end
      else if (i_clock_en)
      begin
         if (write_control)
         begin
            transmit_flag <= i_write_data[`SC_TX_FLAG];
            receive_flag <= i_write_data[`SC_RX_FLAG];
            receive_ninth_bit <= i_write_data[`SC_RX_NINTH];
            if (framing_detect_enable)
               framing_error_flag <= i_write_data[`SC_MODE_HIGH]; // R4
         end
         if (tx_set_flag)
            transmit_flag <= 1'b1; // R10
         if (rx_accept)
         begin
            receive_flag <= 1'b1; // R11
            receive_ninth_bit <= next_rx_ninth_bit; // R9
         end
         if (rx_done && rx_stop_bad && framing_detect_enable)
            framing_error_flag <= 1'b1; // R4
      end
   end

   // Read data stand in the cycle after the read strobe.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
         o_read_data <= `RST_BYTE;
      else if (i_clock_en)
      begin
         o_read_data <= `RST_BYTE;
         if (i_read)
         begin
            case (i_address)
               `OFS_SERIAL_CONTROL:
                  o_read_data <= {framing_detect_enable ? framing_error_flag : mode_select_high, // R3
                     mode_select_low, multiprocessor_bit, receive_enable, transmit_ninth_bit,
                     receive_ninth_bit, transmit_flag, receive_flag};
               `OFS_SERIAL_DATA_BUFFER: o_read_data <= rx_buffer; // R12
               `OFS_POWER_CONTROL: o_read_data <= {baud_doubler, framing_detect_enable, 6'h00};
               `OFS_INT_ENABLE: o_read_data <= {global_int_enable, 2'h0, serial_zero_int_enable, 4'h0};
               `OFS_SERIAL_SLAVE_ADDRESS: o_read_data <= serial_slave_address;
               `OFS_SLAVE_ADDRESS_MASK: o_read_data <= slave_address_mask;
               default: o_read_data <= `RST_BYTE;
            endcase
         end
      end
   end

   assign o_serial_irq = (transmit_flag || receive_flag) && serial_zero_int_enable && global_int_enable; // R14

   // Transmitter. A data write while a frame is going out is ignored, so software waits for the transmit flag and, in modes 1-3, the end of the stop bit.
   assign tx_set_flag = i_clock_en && (((mode == MODE_SYNC) && (tx_state == FR_DATA) && rate.shift_tick
      && (tx_bit == `DATA_BITS_LAST)) || ((mode != MODE_SYNC) && (tx_state == FR_STOP) && (tx_os == 4'h0)
      && rate.os_tick)); // R10

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         tx_state <= FR_IDLE;
         tx_os <= 4'h0;
         tx_bit <= 3'h0;
         tx_shift <= 9'h1FF;
      end
      else if (i_clock_en)
      begin
         case (tx_state)
            FR_IDLE:
               if (write_data && (rx_state == FR_IDLE || mode != MODE_SYNC))
               begin
                  tx_shift <= {transmit_ninth_bit, i_write_data}; // R8 R12
                  tx_os <= 4'h0;
                  tx_bit <= 3'h0;
                  tx_state <= FR_START;
               end
            FR_START:
               if (mode == MODE_SYNC)
               begin
                  if (rate.shift_tick)
                     tx_state <= FR_DATA;
               end
               else if (rate.os_tick)
               begin
                  tx_os <= tx_os + 4'h1;
                  if (tx_os == `OS_PER_BIT_LAST)
                     tx_state <= FR_DATA;
               end
            FR_DATA:
               if ((mode == MODE_SYNC) ? rate.shift_tick : (rate.os_tick && tx_os == `OS_PER_BIT_LAST))
               begin
                  tx_os <= 4'h0;
                  tx_bit <= tx_bit + 3'h1;
                  tx_shift <= {1'b1, tx_shift[8:1]};
                  if (tx_bit == `DATA_BITS_LAST)
                     tx_state <= (mode == MODE_SYNC) ? FR_IDLE
                        : (mode == MODE_ASYNC_TEN) ? FR_STOP : FR_NINTH; // R1
               end
               else if (rate.os_tick && mode != MODE_SYNC)
                  tx_os <= tx_os + 4'h1;
            FR_NINTH:
               if (rate.os_tick)
               begin
                  tx_os <= tx_os + 4'h1;
                  if (tx_os == `OS_PER_BIT_LAST)
                  begin
                     tx_shift <= 9'h1FF;
                     tx_state <= FR_STOP;
                  end
               end
            FR_STOP:
               if (rate.os_tick)
               begin
                  tx_os <= tx_os + 4'h1;
                  if (tx_os == `OS_PER_BIT_LAST)
                     tx_state <= FR_IDLE;
               end
            default: tx_state <= FR_IDLE;
         endcase
      end
   end

   // Pin drive. In mode 0 the transmit pin carries the shift clock and the receive pin the data.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         o_txd <= 1'b1;
         o_rxd <= 1'b1;
         o_rxd_oe <= 1'b0;
      end
      else if (i_clock_en)
      begin
         if (mode == MODE_SYNC)
         begin
            o_txd <= !(((tx_state == FR_DATA) || (rx_state == FR_DATA)) && rate.shift_low);
            o_rxd <= tx_shift[0];
            o_rxd_oe <= (tx_state == FR_DATA);
         end
         else
         begin
            o_txd <= (tx_state == FR_START) ? 1'b0 : (tx_state == FR_STOP || tx_state == FR_IDLE) ? 1'b1
               : tx_shift[0];
            o_rxd <= 1'b1;
            o_rxd_oe <= 1'b0;
         end
      end
   end

   // Input pin synchroniser: a change is taken once the second and third stages agree.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         rx_sync1 <= 1'b1;
         rx_sync2 <= 1'b1;
         rx_sync3 <= 1'b1;
         rx_level <= 1'b1;
         rx_level_prev <= 1'b1;
      end
      else if (i_clock_en)
      begin
         rx_sync1 <= i_rxd;
         rx_sync2 <= rx_sync1;
         rx_sync3 <= rx_sync2;
         if (rx_sync2 == rx_sync3)
            rx_level <= rx_sync3;
         rx_level_prev <= rx_level;
      end
   end

   // Frame completion and the multiprocessor filter.
   always_comb
   begin
      rx_done = 1'b0;
      rx_stop_bad = 1'b0;
      next_rx_ninth_bit = receive_ninth_bit;
      rx_accept = 1'b0;
      if (mode == MODE_SYNC)
      begin
         rx_done = i_clock_en && (rx_state == FR_DATA) && rate.shift_tick && (rx_bit == `DATA_BITS_LAST);
         rx_accept = rx_done && !receive_flag; // R11
      end
      else
      begin
         rx_done = i_clock_en && (rx_state == FR_STOP) && rate.os_tick && (rx_os == `OS_MID_BIT);
         rx_stop_bad = !rx_level; // R4
         if (mode == MODE_ASYNC_TEN)
         begin
            if (!multiprocessor_bit)
               next_rx_ninth_bit = rx_level; // R9
            rx_accept = rx_done && !receive_flag && (!multiprocessor_bit || rx_level); // R6 R11
         end
         else
         begin
            next_rx_ninth_bit = rx_ninth; // R9
            rx_accept = rx_done && !receive_flag && (!multiprocessor_bit || (rx_ninth // R5
               && (((rx_shift ^ serial_slave_address) & slave_address_mask) == 8'h00))); // R16
         end
      end
   end

   // Receiver. A frame that completes while the receive flag is still set is dropped.
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         rx_state <= FR_IDLE;
         rx_os <= 4'h0;
         rx_bit <= 3'h0;
         rx_shift <= `RST_BYTE;
         rx_ninth <= 1'b0;
         rx_buffer <= `RST_BYTE;
      end
      else if (i_clock_en)
      begin
         if (rx_accept)
            rx_buffer <= (mode == MODE_SYNC) ? {rx_level, rx_shift[7:1]} : rx_shift; // R12
         case (rx_state)
            FR_IDLE:
            begin
               rx_os <= 4'h0;
               rx_bit <= 3'h0;
               if (receive_enable) // R7
               begin
                  if (mode == MODE_SYNC)
                  begin
                     if (!receive_flag && tx_state == FR_IDLE && !write_data)
                        rx_state <= FR_START;
                  end
                  else if (rx_level_prev && !rx_level)
                     rx_state <= FR_START;
               end
            end
            FR_START:
               if (!receive_enable)
                  rx_state <= FR_IDLE; // R7
               else if (mode == MODE_SYNC)
               begin
                  if (rate.shift_tick)
                     rx_state <= FR_DATA;
               end
               else if (rate.os_tick)
               begin
                  rx_os <= rx_os + 4'h1;
                  if (rx_os == `OS_MID_BIT && rx_level)
                     rx_state <= FR_IDLE;
                  else if (rx_os == `OS_PER_BIT_LAST)
                     rx_state <= FR_DATA;
               end
            FR_DATA:
               if (mode == MODE_SYNC)
               begin
                  if (rate.shift_tick)
                  begin
                     rx_shift <= {rx_level, rx_shift[7:1]};
                     rx_bit <= rx_bit + 3'h1;
                     if (rx_bit == `DATA_BITS_LAST)
                        rx_state <= FR_STOP;
                  end
               end
               else if (rate.os_tick)
               begin
                  rx_os <= rx_os + 4'h1;
                  if (rx_os == `OS_MID_BIT)
                     rx_shift <= {rx_level, rx_shift[7:1]};
                  if (rx_os == `OS_PER_BIT_LAST)
                  begin
                     rx_bit <= rx_bit + 3'h1;
                     if (rx_bit == `DATA_BITS_LAST)
                        rx_state <= (mode == MODE_ASYNC_TEN) ? FR_STOP : FR_NINTH; // R1
                  end
               end
            FR_NINTH:
               if (rate.os_tick)
               begin
                  rx_os <= rx_os + 4'h1;
                  if (rx_os == `OS_MID_BIT)
                     rx_ninth <= rx_level;
                  if (rx_os == `OS_PER_BIT_LAST)
                     rx_state <= FR_STOP;
               end
            FR_STOP:
               if (mode == MODE_SYNC || rx_done)
                  rx_state <= FR_IDLE;
               else if (rate.os_tick)
                  rx_os <= rx_os + 4'h1;
            default: rx_state <= FR_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [verif/serial_port_zero_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_zero_defs.svh"
module serial_port_zero_sva (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_address,
   input wire logic [7:0] i_write_data,
   input wire logic i_write,
   input wire logic i_read,
   input wire logic [7:0] o_read_data,
   input wire logic o_rxd_oe,
   input wire logic o_txd,
   input wire logic o_serial_irq
   );
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   logic mapped;
   assign mapped = i_address inside {`OFS_POWER_CONTROL, `OFS_SERIAL_CONTROL, `OFS_SERIAL_DATA_BUFFER,
      `OFS_INT_ENABLE, `OFS_SERIAL_SLAVE_ADDRESS, `OFS_SLAVE_ADDRESS_MASK};
   sequence addr_write;
      i_write && i_address == `OFS_SERIAL_SLAVE_ADDRESS;
   endsequence
   sequence addr_read;
      i_read && i_address == `OFS_SERIAL_SLAVE_ADDRESS;
   endsequence
   read_idle_a: assert property (!$past(i_read) |-> o_read_data == 8'h00)
      else $error("read data not zero outside the answer cycle");
   unmapped_read_a: assert property ($past(i_read) && !$past(mapped) |-> o_read_data == 8'h00)
      else $error("unmapped read returned nonzero data");
   write_quiet_a: assert property (i_write |=> o_read_data == 8'h00)
      else $error("write produced read data");
   addr_back_a: assert property (addr_write ##2 addr_read |=> o_read_data == $past(i_write_data, 3))
      else $error("slave address read back differs");
   reset_idle_a: assert property ($past(i_sys_rst) |-> o_txd && !o_rxd_oe && !o_serial_irq)
      else $error("outputs not idle after reset");
   sync_low_a: assert property (o_rxd_oe && $fell(o_txd) |-> !o_txd [*2] ##[1:5] o_txd)
      else $error("shift clock low half has wrong length");
   sync_frame_a: assert property ($rose(o_rxd_oe) |-> o_rxd_oe [*8])
      else $error("synchronous frame ended early");
   async_bit_a: assert property (!o_rxd_oe && !$past(o_rxd_oe) && $changed(o_txd) |=> $stable(o_txd) [*7])
      else $error("async bit shorter than minimum");
endmodule
bind serial_port_zero_uart serial_port_zero_sva sva_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
   .i_address(i_address), .i_write_data(i_write_data), .i_write(i_write), .i_read(i_read),
   .o_read_data(o_read_data), .o_rxd_oe(o_rxd_oe), .o_txd(o_txd), .o_serial_irq(o_serial_irq));
`default_nettype wire

// [verif/serial_node_model.sv]
`timescale 1ns/100ps
`default_nettype none
module serial_node_model (
   input wire logic i_clock,
   input wire logic i_line,
   output logic o_line
   );
   initial o_line = 1'b1;
   // Frames hold the start bit in bit 0 and go out least significant bit first.
   task automatic send(input logic [10:0] frame, input int n, input int bit_clocks);
      for (int i = 0; i < n; i++)
      begin
         o_line <= frame[i];
         repeat (bit_clocks) @(posedge i_clock);
      end
      o_line <= 1'b1;
   endtask
   // Bits are sampled near mid-bit so a small skew of the sender does not matter.
   task automatic take(input int n, input int bit_clocks, output logic [10:0] frame);
      int waited = 0;
      frame = 11'h7FF;
      while (i_line !== 1'b0 && waited < 400)
      begin
         @(negedge i_clock);
         waited++;
      end
      repeat (bit_clocks / 2) @(negedge i_clock);
      for (int i = 0; i < n; i++)
      begin
         frame[i] = i_line;
         repeat (bit_clocks) @(negedge i_clock);
      end
   endtask
endmodule
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "serial_port_zero_defs.svh"
module testbench;
   logic i_clock, i_sys_rst, i_clock_en, i_write, i_read, i_timer_tick, i_rxd;
   logic o_rxd, o_rxd_oe, o_txd, o_serial_irq;
   logic [7:0] i_address, i_write_data, o_read_data, d;
   int n_mismatch, n_checks;
   logic [7:0] regs [6] = '{`OFS_POWER_CONTROL, `OFS_SERIAL_CONTROL, `OFS_SERIAL_DATA_BUFFER,
      `OFS_INT_ENABLE, `OFS_SERIAL_SLAVE_ADDRESS, `OFS_SLAVE_ADDRESS_MASK};
   // Frames are {stop, ninth, data, start}; the last two are 10-bit mode 1 frames.
   logic [7:0] rx_ctrl [8] = '{8'h90, 8'hB0, 8'hB0, 8'hB0, 8'h80, 8'hF0, 8'h70, 8'h50};
   logic [10:0] rx_frame [8] = '{11'h478, 11'h4B4, 11'h6B6, 11'h694, 11'h478, 11'h6B6, 11'h102, 11'h302};
   logic [7:0] rx_exp [8] = '{8'h91, 8'hB0, 8'hB5, 8'hB0, 8'h80, 8'hF5, 8'h70, 8'h55};
   logic [7:0] ie_set [3] = '{8'h10, 8'h80, 8'h90};
   serial_port_zero_uart dut_u (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_clock_en(i_clock_en),
      .i_address(i_address), .i_write_data(i_write_data), .i_write(i_write), .i_read(i_read),
      .o_read_data(o_read_data), .i_timer_tick(i_timer_tick), .i_rxd(i_rxd), .o_rxd(o_rxd),
      .o_rxd_oe(o_rxd_oe), .o_txd(o_txd), .o_serial_irq(o_serial_irq));
   serial_node_model node_u (.i_clock(i_clock), .i_line(o_txd), .o_line(i_rxd));
   initial
   begin
      i_clock = 1'b0;
      forever #50 i_clock = ~i_clock;
   end
   // A tick every second clock gives 64 clocks a bit in modes 1 and 3, as in mode 2.
   always @(posedge i_clock) i_timer_tick <= (i_timer_tick !== 1'b1);
   task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge i_clock);
      i_write <= 1'b1;
      i_address <= a;
      i_write_data <= v;
      @(posedge i_clock);
      i_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge i_clock);
      i_read <= 1'b1;
      i_address <= a;
      @(posedge i_clock);
      i_read <= 1'b0;
      @(negedge i_clock);
      v = o_read_data;
   endtask
   task automatic tx_case(input logic [7:0] ctrl, input logic [10:0] frame, input int n, input int bit_clocks);
      logic [10:0] got;
      wr(`OFS_SERIAL_CONTROL, ctrl);
      wr(`OFS_SERIAL_DATA_BUFFER, frame[8:1]);
      node_u.take(n, bit_clocks, got);
      check("sent frame", frame, got);
      rd(`OFS_SERIAL_CONTROL, d);
      check("control", 11'(ctrl | 8'h02), 11'(d));
      repeat (bit_clocks) @(posedge i_clock);
   endtask
   task automatic rx_case(input logic [7:0] ctrl, input logic [10:0] frame, input int n, input logic [7:0] exp);
      logic [7:0] mask;
      mask = exp[0] ? 8'hFF : 8'hFB;
      wr(`OFS_SERIAL_CONTROL, ctrl);
      node_u.send(frame, n, 64);
      repeat (8) @(posedge i_clock);
      rd(`OFS_SERIAL_CONTROL, d);
      check("control", 11'(exp & mask), 11'(d & mask));
      rd(`OFS_SERIAL_DATA_BUFFER, d);
      if (exp[0])
         check("received data", 11'(frame[8:1]), 11'(d));
   endtask
   task automatic sync_tx(input logic [7:0] ctrl, input logic [7:0] data, input int period);
      logic [7:0] got = 8'h00;
      logic prev = 1'b1;
      int k = 0;
      int first = 0;
      wr(`OFS_SERIAL_CONTROL, ctrl);
      wr(`OFS_SERIAL_DATA_BUFFER, data);
      for (int c = 0; c < 140; c++)
      begin
         @(negedge i_clock);
         if (o_txd === 1'b1 && prev === 1'b0 && k < 8)
         begin
            if (k == 0)
               first = c;
            got[k] = o_rxd;
            k++;
            if (k == 8)
               check("shift period", 11'(7 * period), 11'(c - first));
         end
         prev = o_txd;
      end
      check("shifted data", 11'(data), 11'(got));
      rd(`OFS_SERIAL_CONTROL, d);
      check("control", 11'(ctrl | 8'h02), 11'(d));
   endtask
   task automatic stop_test;
      $display("checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (40000) @(posedge i_clock);
      n_mismatch++;
      $display("unexpected watchdog expiry: expected done, seen running");
      stop_test();
   end
   initial
   begin
      {i_sys_rst, i_clock_en, i_write, i_read} = 4'b1100;
      {i_address, i_write_data} = 16'h0000;
      n_mismatch = 0;
      n_checks = 0;
      repeat (3) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      foreach (regs[i])
      begin
         rd(regs[i], d);
         check("reset value", 11'h000, 11'(d));
      end
      wr(8'h9A, 8'hFF);
      rd(8'h9A, d);
      check("unmapped", 11'h000, 11'(d));
      wr(`OFS_SERIAL_SLAVE_ADDRESS, 8'h5A);
      rd(`OFS_SERIAL_SLAVE_ADDRESS, d);
      check("slave address", 11'h05A, 11'(d));
      wr(`OFS_SLAVE_ADDRESS_MASK, 8'hFE);
      i_clock_en <= 1'b0;
      wr(`OFS_SLAVE_ADDRESS_MASK, 8'h00);
      i_clock_en <= 1'b1;
      rd(`OFS_SLAVE_ADDRESS_MASK, d);
      check("address mask", 11'h0FE, 11'(d));
      tx_case(8'h88, 11'h74A, 11, 64);
      wr(`OFS_POWER_CONTROL, 8'h80);
      tx_case(8'h80, 11'h478, 11, 32);
      wr(`OFS_POWER_CONTROL, 8'h00);
      tx_case(8'h40, 11'h702, 10, 64);
      for (int i = 0; i < 8; i++)
         rx_case(rx_ctrl[i], rx_frame[i], (i < 6) ? 11 : 10, rx_exp[i]);
      wr(`OFS_POWER_CONTROL, 8'h40);
      rx_case(8'h50, 11'h102, 10, 8'hD1);
      wr(`OFS_SERIAL_CONTROL, 8'h50);
      rd(`OFS_SERIAL_CONTROL, d);
      check("cleared framing flag", 11'h050, 11'(d));
      wr(`OFS_POWER_CONTROL, 8'h00);
      sync_tx(8'h20, 8'h96, 4);
      sync_tx(8'h00, 8'h3C, 12);
      for (int i = 0; i < 3; i++)
      begin
         wr(`OFS_INT_ENABLE, ie_set[i]);
         @(negedge i_clock);
         check("interrupt", 11'(ie_set[i][7] & ie_set[i][4]), 11'(o_serial_irq));
      end
      wr(`OFS_SERIAL_CONTROL, 8'h00);
      @(negedge i_clock);
      check("interrupt", 11'h000, 11'(o_serial_irq));
      stop_test();
   end
endmodule
`default_nettype wire
